// ### hdl/composite_video_sync_timing.sv
// Horizontal and vertical sync timing generator for a composite video encoder
`timescale 1ns/1ps
module composite_video_sync_timing (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Standard select and picture data
    input wire video_timing_pkg::std_type std_sel_in,
    input wire logic [9:0] pixel_in,
    // Picture data request
    output logic pixel_req_out,
    // Timing flags
    output logic sync_out,
    output logic burst_out,
    output logic active_out,
    output logic porch_out,
    output logic field_out,
    output logic [10:0] h_count_out,
    // DAC code
    output logic [9:0] video_code_out
);
    import video_timing_pkg::*;

    std_type mode; // Standard in force for the frame
    logic [10:0] h_cnt; // Clock within the line
    logic [10:0] line_last; // Final clock of a line
    logic [10:0] half; // Half-line length
    logic [10:0] p; // Clock within the half-line
    logic [10:0] burst_start;
    logic [10:0] act_start;
    logic [10:0] act_end;
    logic [10:0] pre_tick_b; // Clock before mid-line
    logic tick; // Half-line advance, one clock early
    logic [10:0] hl; // Half-line within the field
    logic field;
    kind_type kind;
    logic vbi; // Picture-free lines
    logic frame_end;
    logic [1:0] phase; // Burst waveform phase
    logic next_sync;
    logic next_burst;
    logic next_active;
    logic next_porch;
    logic margin; // Overscan region of the active window
    logic [9:0] next_code;
    logic [9:0] ramp_level;
    logic ramp_busy;
    kind_type kind_q; // Kind aligned to registered outputs
    logic [10:0] p_q; // Half-line position aligned to outputs

    // Picture sample mapped from black upward, clipped at white
    function automatic logic [9:0] luma_code(input logic [9:0] px);
        if (px > LEVEL_WHITE - LEVEL_BLACK) begin
            return LEVEL_WHITE;
        end
        return LEVEL_BLACK + px;
    endfunction

    // Interval figures for the standard in force
    always_comb begin
        line_last = pick(mode, LINE_CLKS_N, LINE_CLKS_P) - 11'h001;
        half = pick(mode, HALF_CLKS_N, HALF_CLKS_P);
        burst_start = pick(mode, BURST_START_N, BURST_START_P);
        act_start = pick(mode, ACT_START_N, ACT_START_P);
        act_end = act_start + pick(mode, ACT_LEN_N, ACT_LEN_P);
        pre_tick_b = half - 11'h001;
        p = (h_cnt >= half) ? h_cnt - half : h_cnt;
        tick = (h_cnt == line_last) || (h_cnt == pre_tick_b);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            h_cnt <= 11'h000;
        end else if (h_cnt == line_last) begin
            h_cnt <= 11'h000;
        end else begin
            h_cnt <= h_cnt + 11'h001;
        end
    end

    // standard taken at reset, and otherwise only at frame boundary
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mode <= std_sel_in;
        end else if (h_cnt == line_last && frame_end) begin
            mode <= std_sel_in;
        end
    end

    // half-line and field position, field rate follows
    field_counter u_field (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .tick_in(tick),
        .mode_in(mode),
        .half_index_out(hl),
        .field_out(field),
        .kind_out(kind),
        .vbi_out(vbi),
        .frame_end_out(frame_end)
    );

    // Pulse windows per half-line kind
    always_comb begin
        unique case (kind)
            // normal sync tip at line start
            KIND_NORMAL: next_sync = h_cnt < SYNC_TIP_LEN;
            // equalizing width; placed after its delay
            KIND_EQUAL: next_sync = p >= pick(mode, EQ_DELAY_N, EQ_DELAY_P)
                && p < pick(mode, EQ_DELAY_N, EQ_DELAY_P) + EQ_WIDTH;
            // broad pulse; serration fills the rest
            KIND_BROAD: next_sync = p < pick(mode, BROAD_WIDTH_N, BROAD_WIDTH_P);
            default: next_sync = 1'b0;
        endcase
    end

    // Burst, active, porch and overscan windows
    always_comb begin
        // burst start; burst length, normal lines only
        next_burst = kind == KIND_NORMAL && h_cnt >= burst_start
            && h_cnt < burst_start + pick(mode, BURST_LEN_N, BURST_LEN_P);
        // active start; active length, none in blanking
        next_active = !vbi && h_cnt >= act_start && h_cnt < act_end;
        next_porch = h_cnt >= act_end
            && h_cnt < act_end + pick(mode, PORCH_LEN_N, PORCH_LEN_P);
        margin = h_cnt < act_start + pick(mode, BACK_OVERSCAN_N, BACK_OVERSCAN_P)
            || h_cnt >= act_end - pick(mode, FRONT_OVERSCAN_N, FRONT_OVERSCAN_P);
        pixel_req_out = next_active && !margin;
    end

    // pulse edges shaped in four steps
    sync_ramp u_ramp (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .low_in(sync_out),
        .level_out(ramp_level),
        .busy_out(ramp_busy)
    );

    // Burst phase runs freely
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    // Output level selection, from the unregistered windows
    // Code then stands in the same cycles as burst_out and active_out
    always_comb begin
        if (ramp_busy) begin
            // Sync ramp or tip
            next_code = ramp_level;
        end else if (next_burst) begin
            // burst swings 20 IRE each way
            next_code = phase[1] ? LEVEL_BLANK + BURST_SWING : LEVEL_BLANK - BURST_SWING;
        end else if (next_active) begin
            next_code = margin ? LEVEL_BLACK : luma_code(pixel_in);
        end else begin
            // Blanking
            next_code = LEVEL_BLANK;
        end
    end

    // Registered timing flags
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sync_out <= 1'b0;
            burst_out <= 1'b0;
            active_out <= 1'b0;
            porch_out <= 1'b0;
            field_out <= 1'b0;
            h_count_out <= 11'h000;
            kind_q <= KIND_NORMAL;
            p_q <= 11'h000;
        end else begin
            sync_out <= next_sync;
            burst_out <= next_burst;
            active_out <= next_active;
            porch_out <= next_porch;
            field_out <= field;
            h_count_out <= h_cnt;
            kind_q <= kind;
            p_q <= p;
        end
    end

    // Registered DAC code
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            video_code_out <= LEVEL_BLANK;
        end else begin
            video_code_out <= next_code;
        end
    end

    // Checking helpers: run lengths of the flags
    logic [10:0] burst_run;
    logic [10:0] active_run;
    logic [10:0] porch_run;
    logic [10:0] sync_run;
    logic [10:0] gap_run;
    logic [10:0] since_rise;
    logic [18:0] field_run;
    logic field_armed;
    logic prev_broad;
    kind_type rise_kind;

    // Run counters
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            burst_run <= 11'h000;
            active_run <= 11'h000;
            porch_run <= 11'h000;
            sync_run <= 11'h000;
            gap_run <= 11'h000;
        end else begin
            burst_run <= burst_out ? burst_run + 11'h001 : 11'h000;
            active_run <= active_out ? active_run + 11'h001 : 11'h000;
            porch_run <= porch_out ? porch_run + 11'h001 : 11'h000;
            sync_run <= sync_out ? sync_run + 11'h001 : 11'h000;
            gap_run <= sync_out ? 11'h000 : gap_run + 11'h001;
        end
    end

    // Pulse spacing and field length helpers
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            since_rise <= 11'h000;
            rise_kind <= KIND_NORMAL;
            prev_broad <= 1'b0;
            field_run <= 19'h00000;
            field_armed <= 1'b0;
        end else begin
            since_rise <= (sync_out && since_rise == 11'h000) ? 11'h001
                : ($rose(sync_out) ? 11'h001 : since_rise + 11'h001);
            if ($rose(sync_out)) begin
                rise_kind <= kind_q;
            end
            if ($fell(sync_out)) begin
                prev_broad <= kind_q == KIND_BROAD;
            end
            field_run <= (field_out != field) ? 19'h00001 : field_run + 19'h00001;
            if (field_out != field) begin
                field_armed <= 1'b1;
            end
        end
    end

    a_line_length: assert property (@(posedge clk_in) disable iff (srst_in)
        $fell(h_count_out != 11'h000) |-> $past(h_count_out) + 11'h001
            == pick($past(mode, 2), LINE_CLKS_N, LINE_CLKS_P))
        else $error("line length wrong");

    a_burst_start: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(burst_out) |-> $past(h_cnt) == burst_start)
        else $error("burst starts at wrong clock");

    a_burst_length: assert property (@(posedge clk_in) disable iff (srst_in)
        $fell(burst_out) |-> burst_run == pick(mode, BURST_LEN_N, BURST_LEN_P))
        else $error("burst length wrong");

    a_active_start: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(active_out) |-> h_count_out == act_start)
        else $error("active video starts at wrong clock");

    a_active_length: assert property (@(posedge clk_in) disable iff (srst_in)
        $fell(active_out) |-> active_run == pick(mode, ACT_LEN_N, ACT_LEN_P))
        else $error("active video length wrong");

    a_porch_timing: assert property (@(posedge clk_in) disable iff (srst_in)
        $fell(porch_out) && mode == STD_NTSC |-> porch_run == PORCH_LEN_N)
        else $error("front porch length wrong");

    a_pulse_width: assert property (@(posedge clk_in) disable iff (srst_in)
        $fell(sync_out) |-> sync_run == ((kind_q == KIND_NORMAL) ? SYNC_TIP_LEN
            : (kind_q == KIND_EQUAL) ? EQ_WIDTH
            : pick(mode, BROAD_WIDTH_N, BROAD_WIDTH_P)))
        else $error("pulse width wrong");

    a_ramp_steps: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(sync_out) |-> ##2 video_code_out == LEVEL_BLANK - RAMP_STEP
            ##3 video_code_out == LEVEL_SYNC)
        else $error("sync edge ramp wrong");

    a_overscan_black: assert property (@(posedge clk_in) disable iff (srst_in)
        next_active && margin && !ramp_busy && !next_burst |=> video_code_out == LEVEL_BLACK)
        else $error("overscan margin not black");

    a_half_period: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(sync_out) && kind_q != KIND_NORMAL && rise_kind == kind_q
            |-> since_rise == half)
        else $error("vertical pulse spacing wrong");

    a_eq_delay: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(sync_out) && kind_q == KIND_EQUAL
            |-> p_q == pick(mode, EQ_DELAY_N, EQ_DELAY_P))
        else $error("equalizing pulse placed wrong");

    a_serration_gap: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(sync_out) && kind_q == KIND_BROAD && prev_broad |-> gap_run == SERRATION_LEN)
        else $error("serration interval wrong");

    a_video_levels: assert property (@(posedge clk_in) disable iff (srst_in)
        next_active && !ramp_busy && !next_burst
            |=> video_code_out >= LEVEL_BLACK && video_code_out <= LEVEL_WHITE)
        else $error("picture level outside black to white");

    a_field_rate: assert property (@(posedge clk_in) disable iff (srst_in)
        field_armed && field_out != field && mode == STD_NTSC |-> field_run == FIELD_CLKS_N)
        else $error("field length wrong");

    a_mode_switch: assert property (@(posedge clk_in) disable iff (srst_in)
        mode != $past(mode) |-> h_cnt == 11'h000 && hl == 11'h000 && !field)
        else $error("standard changed mid-frame");

endmodule

// ### hdl/field_counter.sv
// Half-line and field counter with vertical interval classification
`timescale 1ns/1ps
module field_counter (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Advance and standard
    input wire logic tick_in,
    input wire video_timing_pkg::std_type mode_in,
    // Position in the frame
    output logic [10:0] half_index_out,
    output logic field_out,
    output video_timing_pkg::kind_type kind_out,
    output logic vbi_out,
    output logic frame_end_out
);
    import video_timing_pkg::*;

    logic [10:0] last_half; // Final half-line of a field
    logic [10:0] group; // Length of one pulse group

    // Field dimensions for the selected standard
    always_comb begin
        last_half = pick(mode_in, FIELD_HALVES_N, FIELD_HALVES_P) - 11'h001;
        group = pick(mode_in, EQ_GROUP_N, EQ_GROUP_P);
    end

    // Count half-lines, toggle field at wrap
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            half_index_out <= 11'h000;
            field_out <= 1'b0;
        end else if (tick_in) begin
            if (half_index_out == last_half) begin
                half_index_out <= 11'h000;
                field_out <= ~field_out;
            end else begin
                half_index_out <= half_index_out + 11'h001;
            end
        end
    end

    // Pre-equalizing, broad, post-equalizing, then normal lines
    always_comb begin
        if (half_index_out < group) begin
            kind_out = KIND_EQUAL;
        end else if (half_index_out < {group[9:0], 1'b0}) begin
            kind_out = KIND_BROAD;
        end else if (half_index_out < group + {group[9:0], 1'b0}) begin
            kind_out = KIND_EQUAL;
        end else begin
            kind_out = KIND_NORMAL;
        end
        vbi_out = half_index_out < pick(mode_in, VBI_HALVES_N, VBI_HALVES_P);
        frame_end_out = field_out && (half_index_out == last_half);
    end

endmodule

// ### hdl/sync_ramp.sv
// Four-step edge shaper for sync, equalizing and broad pulses
`timescale 1ns/1ps
module sync_ramp (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Pulse request
    input wire logic low_in,
    // Shaped level
    output logic [9:0] level_out,
    output logic busy_out
);
    import video_timing_pkg::*;

    logic [2:0] pos; // Steps taken below blanking

    // Walk one step per clock toward tip or blanking
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pos <= 3'h0;
        end else if (low_in && pos != RAMP_CLKS) begin
            pos <= pos + 3'h1;
        end else if (!low_in && pos != 3'h0) begin
            pos <= pos - 3'h1;
        end
    end

    // Level falls by one step per position
    always_comb begin
        level_out = LEVEL_BLANK - ({7'h00, pos} * RAMP_STEP);
        busy_out = pos != 3'h0;
    end

endmodule

// ### hdl/video_timing_pkg.sv
// Constants and types shared by the composite video sync timing generator
package video_timing_pkg;

    // Standard select
    typedef enum logic {
        STD_NTSC = 1'b0,
        STD_PAL  = 1'b1
    } std_type;

    // Kind of the current half-line
    typedef enum logic [1:0] {
        KIND_NORMAL = 2'b00,
        KIND_EQUAL  = 2'b01,
        KIND_BROAD  = 2'b10
    } kind_type;

    // Horizontal intervals, in clocks
    localparam logic [10:0] LINE_CLKS_N = 11'h6b4;
    localparam logic [10:0] LINE_CLKS_P = 11'h6c0;
    localparam logic [10:0] BURST_START_N = 11'h090;
    localparam logic [10:0] BURST_START_P = 11'h099;
    localparam logic [10:0] BURST_LEN_N = 11'h03f;
    localparam logic [10:0] BURST_LEN_P = 11'h042;
    localparam logic [10:0] ACT_START_N = 11'h0ff;
    localparam logic [10:0] ACT_START_P = 11'h117;
    localparam logic [10:0] ACT_LEN_N = 11'h58f;
    localparam logic [10:0] ACT_LEN_P = 11'h585;
    localparam logic [10:0] PORCH_LEN_N = 11'h024;
    localparam logic [10:0] PORCH_LEN_P = 11'h027;
    localparam logic [10:0] SYNC_TIP_LEN = 11'h080;
    localparam logic [2:0] RAMP_CLKS = 3'h4;
    localparam logic [10:0] BACK_OVERSCAN_N = 11'h009;
    localparam logic [10:0] BACK_OVERSCAN_P = 11'h00e;
    localparam logic [10:0] FRONT_OVERSCAN_N = 11'h008;
    localparam logic [10:0] FRONT_OVERSCAN_P = 11'h00d;

    // Vertical interval pulses, in clocks
    localparam logic [10:0] HALF_CLKS_N = 11'h35a;
    localparam logic [10:0] HALF_CLKS_P = 11'h360;
    localparam logic [10:0] EQ_WIDTH = 11'h040;
    localparam logic [10:0] EQ_DELAY_N = 11'h026;
    localparam logic [10:0] EQ_DELAY_P = 11'h029;
    localparam logic [10:0] BROAD_WIDTH_N = 11'h2da;
    localparam logic [10:0] BROAD_WIDTH_P = 11'h2e0;
    localparam logic [10:0] SERRATION_LEN = 11'h080;

    // Field structure, in half-lines
    localparam logic [10:0] FIELD_HALVES_N = 11'h20d;
    localparam logic [10:0] FIELD_HALVES_P = 11'h271;
    localparam logic [10:0] EQ_GROUP_N = 11'h006;
    localparam logic [10:0] EQ_GROUP_P = 11'h005;
    localparam logic [10:0] VBI_HALVES_N = 11'h028;
    localparam logic [10:0] VBI_HALVES_P = 11'h032;
    // Clocks per NTSC field: 1716 * 525 / 2
    localparam logic [18:0] FIELD_CLKS_N = 19'h6df92;

    // DAC codes, 4 codes per IRE above or below blanking
    localparam logic [9:0] LEVEL_BLANK = 10'h0f0;
    localparam logic [9:0] LEVEL_SYNC = 10'h050;
    localparam logic [9:0] LEVEL_BLACK = 10'h10e;
    localparam logic [9:0] LEVEL_WHITE = 10'h280;
    localparam logic [9:0] BURST_SWING = 10'h050;
    localparam logic [9:0] RAMP_STEP = 10'h028;

    // Choose the NTSC or PAL figure of a pair
    function automatic logic [10:0] pick(input std_type s, input logic [10:0] n,
                                         input logic [10:0] p);
        return (s == STD_PAL) ? p : n;
    endfunction

endpackage

// ### verif/tb_top.sv
// Self-checking bench for the composite video sync timing generator
`timescale 1ns/1ps
module tb_top;
    import video_timing_pkg::*;
    // Clock, reset and stimulus
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    std_type std_sel_in = STD_NTSC;
    logic [9:0] pixel_in = 10'h3ff;
    // Design outputs
    logic pixel_req_out, sync_out, burst_out, active_out, porch_out, field_out;
    logic [10:0] h_count_out;
    logic [9:0] video_code_out;
    // Partner measurements
    logic [19:0] period_out;
    logic [9:0] tip_out;
    // Counters
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;

    always #20 clk_in = ~clk_in;

    composite_video_sync_timing composite_video_sync_timing_i (
        .clk_in(clk_in), .srst_in(srst_in), .std_sel_in(std_sel_in),
        .pixel_in(pixel_in), .pixel_req_out(pixel_req_out), .sync_out(sync_out),
        .burst_out(burst_out), .active_out(active_out), .porch_out(porch_out),
        .field_out(field_out), .h_count_out(h_count_out),
        .video_code_out(video_code_out)
    );

    tv_input_model tv_input_model_i (
        .clk_in(clk_in), .srst_in(srst_in), .video_code_in(video_code_out),
        .period_out(period_out), .tip_out(tip_out)
    );

    // Compare one value and count it
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen %0d expected %0d", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_total++;
            $display("[FAIL] t=%0t run too long", $time);
            close_out();
        end
    end

    // Pick the figure of the chosen standard
    function automatic logic [10:0] sel(input std_type s, input logic [10:0] n,
                                        input logic [10:0] p);
        return (s == STD_PAL) ? p : n;
    endfunction

    // Reset for three clocks with the standard loaded
    task automatic do_reset(input std_type s);
        @(negedge clk_in);
        srst_in = 1'b1;
        std_sel_in = s;
        repeat (3) @(negedge clk_in);
        srst_in = 1'b0;
    endtask

    // Stop at the negedge just after sync_out rises
    task automatic rise_sync(input int lim);
        logic prev;
        int i;
        prev = sync_out;
        for (i = 0; i < lim; i++) begin
            @(negedge clk_in);
            if (sync_out === 1'b1 && prev === 1'b0) return;
            prev = sync_out;
        end
        chk(0, 1);
    endtask

    // Width and rise-to-rise spacing of the current pulse
    task automatic pulse(output int w, output int p);
        logic low_seen;
        w = 1;
        p = 0;
        low_seen = 1'b0;
        do begin
            @(negedge clk_in);
            p++;
            if (sync_out === 1'b1 && !low_seen) w++;
            if (sync_out !== 1'b1) low_seen = 1'b1;
        end while (!(low_seen && sync_out === 1'b1) && p < 2000);
    endtask

    // Equalizing then broad pulses at the start of the field
    task automatic vbi_pulses(input std_type s);
        int w, p, k, neq;
        neq = (s == STD_PAL) ? 5 : 6;
        do_reset(s);
        rise_sync(2000);
        chk(h_count_out, sel(s, EQ_DELAY_N, EQ_DELAY_P));
        for (k = 0; k < neq; k++) begin
            pulse(w, p);
            chk(w, EQ_WIDTH);
            // Last spacing runs into the broad group, so skip it
            if (k < neq - 1) chk(p, sel(s, HALF_CLKS_N, HALF_CLKS_P));
        end
        for (k = 0; k < 4; k++) begin
            pulse(w, p);
            chk(w, sel(s, BROAD_WIDTH_N, BROAD_WIDTH_P));
            chk(p - w, SERRATION_LEN);
        end
    endtask

    // One full picture line, with a refused mid-frame standard change
    // Runs on from the reset of the preceding pulse scan to save time
    task automatic line_scan(input std_type s, input std_type other, input logic [9:0] px);
        int k, sw, bf, bn, bh, af, an, rf, rn, pf, pn, nblk, nwht, nxt, kb;
        int back_margin, front_margin, act, pix;
        back_margin = sel(s, BACK_OVERSCAN_N, BACK_OVERSCAN_P);
        front_margin = sel(s, FRONT_OVERSCAN_N, FRONT_OVERSCAN_P);
        act = sel(s, ACT_START_N, ACT_START_P);
        {sw, bn, bh, an, rn, pn, nblk, nwht, nxt} = '0;
        bf = -1;
        af = -1;
        rf = -1;
        pf = -1;
        kb = -1;
        std_sel_in = other;
        pixel_in = px;
        for (k = 0; k < 60000 && active_out !== 1'b1; k++) @(negedge clk_in);
        rise_sync(2000);
        sw = 1;
        for (k = 1; k <= 1800 && nxt == 0; k++) begin
            @(negedge clk_in);
            // Falling edge ramp of the sync tip
            if (k >= 2 && k <= 5) begin
                chk(video_code_out, int'(LEVEL_BLANK) - (k - 1) * int'(RAMP_STEP));
            end
            if (sync_out === 1'b1 && k < 200) sw++;
            if (burst_out === 1'b1) begin
                if (bf < 0) bf = k;
                bn++;
                if (video_code_out === LEVEL_BLANK + BURST_SWING) bh++;
            end
            if (active_out === 1'b1) begin
                if (af < 0) af = k;
                an++;
            end
            if (pixel_req_out === 1'b1) begin
                if (rf < 0) rf = k;
                rn++;
            end
            if (porch_out === 1'b1) begin
                if (pf < 0) pf = k;
                pn++;
            end
            if (video_code_out === LEVEL_BLACK) begin
                if (kb < 0) kb = k;
                nblk++;
            end
            if (video_code_out === LEVEL_WHITE) nwht++;
            if (sync_out === 1'b1 && k > 200) nxt = k;
        end
        chk(nxt, sel(s, LINE_CLKS_N, LINE_CLKS_P));
        chk(bf, sel(s, BURST_START_N, BURST_START_P));
        chk(bn, sel(s, BURST_LEN_N, BURST_LEN_P));
        chk(bh > 0, 1);
        chk(af, act);
        chk(an, sel(s, ACT_LEN_N, ACT_LEN_P));
        chk(pf, act + an);
        // Porch runs past the line end in the other standard
        if (s == STD_NTSC) chk(pn, PORCH_LEN_N);
        chk(sw, SYNC_TIP_LEN);
        pix = an - back_margin - front_margin;
        chk(rf, act + back_margin - 1);
        chk(kb, act);
        chk(rn, pix);
        // A zero sample maps to black, a full-scale one clips to white
        chk(nblk, (px == 10'h000) ? an : back_margin + front_margin);
        chk(nwht, (px == 10'h000) ? 0 : pix);
        repeat (8) @(negedge clk_in);
        chk(period_out, sel(s, LINE_CLKS_N, LINE_CLKS_P));
        chk(tip_out, LEVEL_SYNC);
    endtask

    // Main sequence
    initial begin
        vbi_pulses(STD_NTSC);
        line_scan(STD_NTSC, STD_PAL, 10'h3ff);
        vbi_pulses(STD_PAL);
        line_scan(STD_PAL, STD_NTSC, 10'h000);
        close_out();
    end
endmodule

// ### verif/tv_input_model.sv
// Model of the analogue TV input that slices sync from the DAC code
`timescale 1ns/1ps
module tv_input_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Composite code from the encoder
    input wire logic [9:0] video_code_in,
    // Measured sync spacing and deepest code seen
    output logic [19:0] period_out,
    output logic [9:0] tip_out
);
    import video_timing_pkg::*;
    // Slicing level half way between blanking and tip
    localparam logic [9:0] SLICE = 10'h0a0;
    logic below; // Code was under the slice last clock
    logic [19:0] run; // Clocks since the last sync entry

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            below <= 1'b0;
            run <= 20'h0;
            period_out <= 20'h0;
        end else begin
            below <= (video_code_in < SLICE);
            run <= run + 20'h1;
            // New sync entry restarts the count
            if (video_code_in < SLICE && !below) begin
                period_out <= run + 20'h1;
                run <= 20'h0;
            end
        end
    end

    // deepest level reached by the tip
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tip_out <= 10'h3ff;
        end else if (video_code_in < tip_out) begin
            tip_out <= video_code_in;
        end
    end
endmodule
